// *** dv/lsf_link_props.sv ***
module lsf_link_props (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Register bus
  input wire logic i_axi_awvalid,
  input wire logic o_axi_awready,
  input wire logic i_axi_wvalid,
  input wire logic o_axi_wready,
  input wire logic [1:0] o_axi_bresp,
  input wire logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic i_axi_arvalid,
  input wire logic o_axi_arready,
  input wire logic [31:0] o_axi_rdata,
  input wire logic o_axi_rvalid,
  input wire logic i_axi_rready,
  // Link and framer
  input wire logic [1:0] o_link_condition,
  input wire logic o_link_condition_report,
  input wire logic i_mac_valid,
  input wire logic o_mac_ready,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_valid,
  input wire logic i_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  // ==========================================
  // Helper: escape byte just sent
  // ==========================================
  logic esc_pend;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
      esc_pend <= 1'h0;
    else if (o_tx_valid && i_tx_ready)
      esc_pend <= (o_tx_data == 8'h7D);
  end

  // ==========================================
  // Properties
  // ==========================================
  sequence s_rtake;
    i_axi_arvalid && o_axi_arready;
  endsequence
  property p_rep_chg;
    o_link_condition_report |-> o_link_condition != $past(o_link_condition);
  endproperty
  property p_chg_rep;
    $changed(o_link_condition) |-> o_link_condition_report;
  endproperty
  property p_esc;
    esc_pend && o_tx_valid && i_tx_ready |-> o_tx_data inside {8'h5E, 8'h5D};
  endproperty
  property p_tx_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
  endproperty
  property p_b_hold;
    o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp);
  endproperty
  property p_r_hold;
    o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata);
  endproperty
  property p_r_lat;
    s_rtake |=> o_axi_rvalid;
  endproperty
  property p_b_lat;
    i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready |-> ##[1:2] o_axi_bvalid;
  endproperty
  property p_mac_gap;
    i_mac_valid && o_mac_ready |=> !o_mac_ready;
  endproperty

  a_rep_chg: assert property (p_rep_chg) else $error("report without change");
  a_chg_rep: assert property (p_chg_rep) else $error("change without report");
  a_esc: assert property (p_esc) else $error("bad escaped byte");
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  a_mac_gap: assert property (p_mac_gap) else $error("mac ready not dropped");

  c_rep: cover property (o_link_condition_report);
  c_esc: cover property (esc_pend && o_tx_valid && i_tx_ready);
  c_stall: cover property (o_tx_valid && !i_tx_ready);
endmodule : lsf_link_props

// *** dv/lsf_phy_model.sv ***
module lsf_phy_model (
  // Clock
  input wire logic i_core_clk,
  // Bench controls
  input wire logic i_fail,
  input wire logic i_degrade,
  input wire logic i_run,
  input wire logic i_stall,
  // Framed stream
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  // Status pins
  output logic o_signal_fail,
  output logic o_signal_degrade,
  output logic o_rxclk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt = 3'h0;
  logic [7:0] got[$];
  initial
  begin
    o_signal_fail = 1'h0;
    o_signal_degrade = 1'h0;
    o_rxclk = 1'h0;
    o_tx_ready = 1'h1;
  end
  always @(posedge i_core_clk)
  begin
    o_signal_fail <= i_fail;
    o_signal_degrade <= i_degrade;
    cnt <= cnt + 3'h1;
    // Slow receive clock, frozen when stopped
    if (i_run && cnt == 3'h7)
      o_rxclk <= ~o_rxclk;
    if (i_tx_valid && o_tx_ready)
      got.push_back(i_tx_data);
    o_tx_ready <= !i_stall || cnt[0];
  end
endmodule : lsf_phy_model

// *** dv/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, fail, degr, run, stall;
  logic awready, wready, bvalid, arready, rvalid, rep, mac_valid, mac_last, mac_ready;
  logic txv, txr, irq, sf, sd, rxclk;
  logic [7:0] awaddr, araddr, mac_data, txd;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, cond;
  int miscompares = 0;
  int num_checks = 0;
  int nrep = 0;
  logic [8:0] pk[4] = '{9'h011, 9'h07E, 9'h122, 9'h17D};
  logic [7:0] ex[10] = '{8'h7E, 8'h11, 8'h7D, 8'h5E, 8'h22, 8'h7E, 8'h7E, 8'h7D, 8'h5D, 8'h7E};

  lsf_link dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_axi_awaddr(awaddr),
    .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp), .o_axi_bvalid(bvalid),
    .i_axi_bready(bready), .i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
    .o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready), .i_signal_fail(sf), .i_signal_degrade(sd),
    .i_phy_receive_clock(rxclk), .o_link_condition(cond), .o_link_condition_report(rep),
    .i_mac_data(mac_data), .i_mac_valid(mac_valid), .i_mac_last(mac_last),
    .o_mac_ready(mac_ready), .o_tx_data(txd), .o_tx_valid(txv), .i_tx_ready(txr), .o_irq(irq));
  lsf_phy_model phy (.i_core_clk(clk), .i_fail(fail), .i_degrade(degr), .i_run(run),
    .i_stall(stall), .i_tx_data(txd), .i_tx_valid(txv), .o_tx_ready(txr),
    .o_signal_fail(sf), .o_signal_degrade(sd), .o_rxclk(rxclk));

  // ==========================================
  // Tasks
  // ==========================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk(bresp, er);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rresp, er);
    chk(rdata, exp);
  endtask : rc
  task automatic mac_send(input logic [8:0] b);
    @(posedge clk);
    mac_data <= b[7:0];
    mac_last <= b[8];
    mac_valid <= 1'h1;
    do
      @(posedge clk);
    while (mac_ready !== 1'h1);
    mac_valid <= 1'h0;
  endtask : mac_send
  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // ==========================================
  // Clock, watchdog, report counter
  // ==========================================
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #400000;
    miscompares++;
    end_of_test();
  end
  always @(posedge clk)
    if (rep === 1'h1)
      nrep <= nrep + 1;

  // ==========================================
  // Tests
  // ==========================================
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, fail, degr, stall, mac_valid, mac_last} = '0;
    {awaddr, araddr, mac_data, wdata} = '0;
    wstrb = 4'hF;
    run = 1'h1;
    rst_n = 1'h0;
    cyc(5);
    rst_n <= 1'h1;
    cyc(2);
    rc(lsf_pkg::REG_CTRL, 32'h18, lsf_pkg::AXI_OKAY);
    rc(lsf_pkg::REG_INT_MASK, 32'h0, lsf_pkg::AXI_OKAY);
    rc(8'h40, 32'h0, lsf_pkg::AXI_SLVERR);
    wr(8'h44, 32'h1, lsf_pkg::AXI_SLVERR);
    // Pin mapping, every combination
    for (int i = 1; i < 5; i++)
    begin
      fail <= i[0];
      degr <= i[1];
      cyc(8);
      chk(cond, {30'h0, i[1], i[0]});
      rc(lsf_pkg::REG_STATUS, {30'h0, i[1], i[0]}, lsf_pkg::AXI_OKAY);
    end
    chk(nrep, 32'h4);
    // Management over both pins active
    fail <= 1'h1;
    degr <= 1'h1;
    cyc(8);
    wr(lsf_pkg::REG_INT_MASK, 32'h1, lsf_pkg::AXI_OKAY);
    wr(lsf_pkg::REG_INT_STATUS, 32'h3, lsf_pkg::AXI_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      wr(lsf_pkg::REG_CTRL, 32'h19 | (i << 1), lsf_pkg::AXI_OKAY);
      cyc(2);
      chk(cond, {30'h0, i[1] & ~i[0], i[0]});
    end
    chk(nrep, 32'h9);
    chk(irq, 1'h1);
    wr(lsf_pkg::REG_INT_STATUS, 32'h1, lsf_pkg::AXI_OKAY);
    cyc(2);
    chk(irq, 1'h0);
    // Stopped receive clock
    fail <= 1'h0;
    degr <= 1'h0;
    wr(lsf_pkg::REG_CTRL, 32'h18, lsf_pkg::AXI_OKAY);
    cyc(8);
    run <= 1'h0;
    cyc(70);
    chk(cond, 2'h1);
    rc(lsf_pkg::REG_STATUS, 32'h5, lsf_pkg::AXI_OKAY);
    run <= 1'h1;
    cyc(30);
    chk(cond, 2'h0);
    // Two frames back to back, far side stalling
    wr(lsf_pkg::REG_INT_STATUS, 32'h3, lsf_pkg::AXI_OKAY);
    stall <= 1'h1;
    for (int i = 0; i < 4; i++)
      mac_send(pk[i]);
    for (int k = 0; k < 300 && phy.got.size() < 10; k++)
      @(posedge clk);
    chk(phy.got.size(), 32'hA);
    for (int j = 0; j < 10; j++)
      chk(phy.got[j], ex[j]);
    rc(lsf_pkg::REG_FRAME_COUNT, 32'h2, lsf_pkg::AXI_OKAY);
    rc(lsf_pkg::REG_INT_STATUS, 32'h2, lsf_pkg::AXI_OKAY);
    chk(irq, 1'h0);
    wr(lsf_pkg::REG_INT_MASK, 32'h2, lsf_pkg::AXI_OKAY);
    cyc(2);
    chk(irq, 1'h1);
    // Framer and watchdog both off: byte held, stopped clock ignored
    wr(lsf_pkg::REG_CTRL, 32'h0, lsf_pkg::AXI_OKAY);
    run <= 1'h0;
    mac_send(9'h1AA);
    cyc(70);
    chk(phy.got.size(), 32'hA);
    chk(cond, 2'h0);
    wr(lsf_pkg::REG_CTRL, 32'h18, lsf_pkg::AXI_OKAY);
    run <= 1'h1;
    cyc(20);
    chk(phy.got.size(), 32'hD);
    chk(phy.got[10], 8'h7E);
    chk(phy.got[11], 8'hAA);
    chk(phy.got[12], 8'h7E);
    chk(cond, 2'h0);
    end_of_test();
  end
endmodule : tb_top

bind lsf_link lsf_link_props u_props (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
  .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready), .i_axi_wvalid(i_axi_wvalid),
  .o_axi_wready(o_axi_wready), .o_axi_bresp(o_axi_bresp), .o_axi_bvalid(o_axi_bvalid),
  .i_axi_bready(i_axi_bready), .i_axi_arvalid(i_axi_arvalid), .o_axi_arready(o_axi_arready),
  .o_axi_rdata(o_axi_rdata), .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(i_axi_rready),
  .o_link_condition(o_link_condition), .o_link_condition_report(o_link_condition_report),
  .i_mac_valid(i_mac_valid), .o_mac_ready(o_mac_ready), .o_tx_data(o_tx_data),
  .o_tx_valid(o_tx_valid), .i_tx_ready(i_tx_ready));

// *** rtl/lsf_hdlc_tx.sv ***
module lsf_hdlc_tx (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Control
  input wire logic i_enable,
  // Packet bytes from the MAC
  input wire logic [7:0] i_mac_data,
  input wire logic i_mac_valid,
  input wire logic i_mac_last,
  output logic o_mac_ready,
  // Framed bytes to the PHY
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  // Events
  output logic o_frame_done,
  output logic o_busy
);

  typedef struct packed {
    lsf_pkg::lsf_tx_state_e state;
    logic [7:0] hold_data;
    logic hold_last;
    logic hold_valid;
    logic mac_ready;
    logic [7:0] tx_data;
    logic tx_valid;
    logic frame_done;
    logic busy;
  } lsf_tx_s;

  localparam lsf_tx_s TX_RESET = '{state: lsf_pkg::TX_IDLE, default: '0};

  lsf_tx_s s;
  lsf_tx_s next_s;
  logic slot;

  always_comb
  begin
    next_s = s;
    next_s.frame_done = 1'b0;
    slot = !s.tx_valid || i_tx_ready;
    if (s.tx_valid && i_tx_ready)
    begin
      next_s.tx_valid = 1'b0;
    end
    // One holding byte; a registered ready costs half rate
    if (s.mac_ready && i_mac_valid)
    begin
      next_s.hold_data = i_mac_data;
      next_s.hold_last = i_mac_last;
      next_s.hold_valid = 1'b1;
    end
    case (s.state)
      lsf_pkg::TX_IDLE:
      begin
        // RULE12: opening flag
        // RULE13: each frame owns a flag
        if (slot && s.hold_valid && i_enable)
        begin
          next_s.tx_data = lsf_pkg::FLAG_BYTE;
          next_s.tx_valid = 1'b1;
          next_s.state = lsf_pkg::TX_DATA;
        end
      end
      lsf_pkg::TX_DATA:
      begin
        if (slot && s.hold_valid)
        begin
          next_s.tx_valid = 1'b1;
          // RULE14: escape flag value
          if (s.hold_data == lsf_pkg::FLAG_BYTE || s.hold_data == lsf_pkg::ESC_BYTE)
          begin
            next_s.tx_data = lsf_pkg::ESC_BYTE;
            next_s.state = lsf_pkg::TX_ESC;
          end
          else
          begin
            // RULE15: bytes kept in order
            next_s.tx_data = s.hold_data;
            next_s.hold_valid = 1'b0;
            next_s.state = s.hold_last ? lsf_pkg::TX_EOF : lsf_pkg::TX_DATA;
          end
        end
      end
      lsf_pkg::TX_ESC:
      begin
        if (slot)
        begin
          next_s.tx_data = s.hold_data ^ lsf_pkg::ESC_XOR;
          next_s.tx_valid = 1'b1;
          next_s.hold_valid = 1'b0;
          next_s.state = s.hold_last ? lsf_pkg::TX_EOF : lsf_pkg::TX_DATA;
        end
      end
      lsf_pkg::TX_EOF:
      begin
        // RULE12: closing flag
        if (slot)
        begin
          next_s.tx_data = lsf_pkg::FLAG_BYTE;
          next_s.tx_valid = 1'b1;
          next_s.frame_done = 1'b1;
          next_s.state = lsf_pkg::TX_IDLE;
        end
      end
      default:
      begin
        next_s.state = lsf_pkg::TX_IDLE;
      end
    endcase
    next_s.mac_ready = !next_s.hold_valid;
    next_s.busy = (next_s.state != lsf_pkg::TX_IDLE) || next_s.tx_valid;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      s <= TX_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_mac_ready = s.mac_ready;
  assign o_tx_data = s.tx_data;
  assign o_tx_valid = s.tx_valid;
  assign o_frame_done = s.frame_done;
  assign o_busy = s.busy;

endmodule : lsf_hdlc_tx

// *** rtl/lsf_link.sv ***
// Summary of operation
// RULE1: Signal-fail input reports PHY failure
// RULE2: Signal-degrade input, tied inactive if unused
// RULE3: Management indications override pin-derived condition
// RULE4: Report to MAC only on condition change
// RULE5: Management indications accepted independent of data
// RULE6: Management: neither indication gives OK
// RULE7: Management fail gives FAIL regardless
// RULE8: Management degrade without fail gives DEGRADE
// RULE9: Pins map to OK, DEGRADE, FAIL, both
// RULE10: Stopped receive clock reports FAIL
// RULE11: PHY local sublayer failure reports FAIL
// RULE12: Flag before packet, flag after packet
// RULE13: Back-to-back packets separated by a flag
// RULE14: Escape every flag-valued packet byte
// RULE15: Frame bytes sent in fixed order
// RULE16: Two-stage synchroniser on status inputs (receive clock: one flop, compared unsynchronised)
module lsf_link (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // AXI4-Lite write address and data
  input wire logic [lsf_pkg::ADDR_W-1:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  // AXI4-Lite read
  input wire logic [lsf_pkg::ADDR_W-1:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  // PHY status
  input wire logic i_signal_fail,
  input wire logic i_signal_degrade,
  input wire logic i_phy_receive_clock,
  // Link condition to the MAC
  output logic [1:0] o_link_condition,
  output logic o_link_condition_report,
  // Packet bytes from the MAC
  input wire logic [7:0] i_mac_data,
  input wire logic i_mac_valid,
  input wire logic i_mac_last,
  output logic o_mac_ready,
  // Framed bytes to the PHY
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  // Interrupt
  output logic o_irq
);

  // ==========================================
  // State
  // ==========================================
  typedef struct packed {
    logic sf_meta;
    logic sf_sync;
    logic sd_meta;
    logic sd_sync;
    logic rxclk_prev;
    logic [lsf_pkg::WATCH_W-1:0] watch_cnt;
    logic rxclk_dead;
    lsf_pkg::lsf_cond_t cond;
    logic report;
    logic [lsf_pkg::CTRL_W-1:0] ctrl;
    logic [lsf_pkg::INT_W-1:0] int_status;
    logic [lsf_pkg::INT_W-1:0] int_mask;
    logic [lsf_pkg::COUNT_W-1:0] frame_count;
    logic irq;
    logic aw_got;
    logic [lsf_pkg::ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lsf_top_s;

  localparam lsf_top_s TOP_RESET = '{
    cond: lsf_pkg::COND_OK,
    ctrl: lsf_pkg::CTRL_RESET,
    int_status: lsf_pkg::INT_RESET,
    int_mask: lsf_pkg::INT_RESET,
    bresp: lsf_pkg::AXI_OKAY,
    rresp: lsf_pkg::AXI_OKAY,
    default: '0
  };

  localparam logic [lsf_pkg::WATCH_W-1:0] WATCH_LIMIT =
    lsf_pkg::WATCH_W'(lsf_pkg::RXCLK_TIMEOUT_CYC);

  lsf_top_s s;
  lsf_top_s next_s;

  logic tx_frame_done;
  logic tx_busy;

  // ==========================================
  // Transmit framer
  // ==========================================
  lsf_hdlc_tx u_tx (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_enable(s.ctrl[lsf_pkg::CTRL_TX_EN]),
    .i_mac_data(i_mac_data),
    .i_mac_valid(i_mac_valid),
    .i_mac_last(i_mac_last),
    .o_mac_ready(o_mac_ready),
    .o_tx_data(o_tx_data),
    .o_tx_valid(o_tx_valid),
    .i_tx_ready(i_tx_ready),
    .o_frame_done(tx_frame_done),
    .o_busy(tx_busy)
  );

  // ==========================================
  // Next state
  // ==========================================
  always_comb
  begin
    lsf_pkg::lsf_cond_t pin_cond;
    lsf_pkg::lsf_cond_t mgmt_cond;
    lsf_pkg::lsf_cond_t new_cond;
    logic [lsf_pkg::INT_W-1:0] int_set;
    logic [lsf_pkg::INT_W-1:0] int_clr;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    pin_cond = lsf_pkg::COND_OK;
    mgmt_cond = lsf_pkg::COND_OK;
    new_cond = lsf_pkg::COND_OK;
    int_set = '0;
    int_clr = '0;
    rd_word = '0;
    rd_hit = 1'b0;
    wr_hit = 1'b0;
    next_s = s;
    next_s.report = 1'b0;

    // RULE16: two flops per fail and degrade pin; receive clock enters the watchdog unsynchronised
    // RULE1: fail pin sampled
    // RULE2: degrade pin sampled
    next_s.sf_meta = i_signal_fail;
    next_s.sf_sync = s.sf_meta;
    next_s.sd_meta = i_signal_degrade;
    next_s.sd_sync = s.sd_meta;

    // Receive clock must toggle well below half the core rate to be seen
    next_s.rxclk_prev = i_phy_receive_clock;
    // RULE10: receive clock watchdog
    if (!s.ctrl[lsf_pkg::CTRL_WATCH_EN] || (i_phy_receive_clock != s.rxclk_prev))
    begin
      next_s.watch_cnt = '0;
      next_s.rxclk_dead = 1'b0;
    end
    else if (s.watch_cnt == WATCH_LIMIT)
    begin
      next_s.rxclk_dead = 1'b1;
    end
    else
    begin
      next_s.watch_cnt = s.watch_cnt + 1'b1;
    end

    // RULE9: pin mapping table
    // RULE11: PHY local failure is FAIL
    pin_cond[lsf_pkg::COND_FAIL] = s.sf_sync | s.rxclk_dead;
    pin_cond[lsf_pkg::COND_DEGRADE] = s.sd_sync;

    // RULE5: register-held indications, any time
    // RULE6: neither gives OK
    // RULE7: fail wins
    // RULE8: degrade without fail
    mgmt_cond[lsf_pkg::COND_FAIL] = s.ctrl[lsf_pkg::CTRL_MGMT_FAIL];
    mgmt_cond[lsf_pkg::COND_DEGRADE] =
      s.ctrl[lsf_pkg::CTRL_MGMT_DEGRADE] & ~s.ctrl[lsf_pkg::CTRL_MGMT_FAIL];

    // RULE3: management takes precedence
    new_cond = s.ctrl[lsf_pkg::CTRL_MGMT_EN] ? mgmt_cond : pin_cond;

    // RULE4: report on change only
    if (new_cond != s.cond)
    begin
      next_s.cond = new_cond;
      next_s.report = 1'b1;
      int_set[lsf_pkg::INT_COND] = 1'b1;
    end

    if (tx_frame_done)
    begin
      next_s.frame_count = s.frame_count + 1'b1;
      int_set[lsf_pkg::INT_FRAME] = 1'b1;
    end

    // ==========================================
    // Write channel
    // ==========================================
    if (i_axi_awvalid && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = i_axi_awaddr;
    end
    if (i_axi_wvalid && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.w_data = i_axi_wdata;
      next_s.w_strb = i_axi_wstrb;
    end
    if (s.bvalid && i_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      case (s.aw_addr)
        lsf_pkg::REG_CTRL:
        begin
          wr_hit = 1'b1;
          if (s.w_strb[lsf_pkg::STRB_LOW])
          begin
            next_s.ctrl = s.w_data[lsf_pkg::CTRL_W-1:0];
          end
        end
        lsf_pkg::REG_INT_STATUS:
        begin
          wr_hit = 1'b1;
          if (s.w_strb[lsf_pkg::STRB_LOW])
          begin
            int_clr = s.w_data[lsf_pkg::INT_W-1:0];
          end
        end
        lsf_pkg::REG_INT_MASK:
        begin
          wr_hit = 1'b1;
          if (s.w_strb[lsf_pkg::STRB_LOW])
          begin
            next_s.int_mask = s.w_data[lsf_pkg::INT_W-1:0];
          end
        end
        lsf_pkg::REG_STATUS, lsf_pkg::REG_FRAME_COUNT:
        begin
          wr_hit = 1'b1;
        end
        default:
        begin
          wr_hit = 1'b0;
        end
      endcase
      next_s.bresp = wr_hit ? lsf_pkg::AXI_OKAY : lsf_pkg::AXI_SLVERR;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    // Set beats clear so an event in the clearing cycle survives
    next_s.int_status = (s.int_status & ~int_clr) | int_set;
    next_s.irq = |(next_s.int_status & next_s.int_mask);

    // ==========================================
    // Read channel
    // ==========================================
    if (s.rvalid && i_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (i_axi_arvalid && s.arready)
    begin
      case (i_axi_araddr)
        lsf_pkg::REG_CTRL:
        begin
          rd_hit = 1'b1;
          rd_word[lsf_pkg::CTRL_W-1:0] = s.ctrl;
        end
        lsf_pkg::REG_STATUS:
        begin
          rd_hit = 1'b1;
          rd_word[lsf_pkg::COND_FAIL] = s.cond[lsf_pkg::COND_FAIL];
          rd_word[lsf_pkg::COND_DEGRADE] = s.cond[lsf_pkg::COND_DEGRADE];
          rd_word[lsf_pkg::STAT_RXCLK_DEAD] = s.rxclk_dead;
          rd_word[lsf_pkg::STAT_TX_BUSY] = tx_busy;
        end
        lsf_pkg::REG_INT_STATUS:
        begin
          rd_hit = 1'b1;
          rd_word[lsf_pkg::INT_W-1:0] = s.int_status;
        end
        lsf_pkg::REG_INT_MASK:
        begin
          rd_hit = 1'b1;
          rd_word[lsf_pkg::INT_W-1:0] = s.int_mask;
        end
        lsf_pkg::REG_FRAME_COUNT:
        begin
          rd_hit = 1'b1;
          rd_word = s.frame_count;
        end
        default:
        begin
          rd_hit = 1'b0;
        end
      endcase
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = rd_hit ? lsf_pkg::AXI_OKAY : lsf_pkg::AXI_SLVERR;
    end
    next_s.arready = !next_s.rvalid;
  end

  // ==========================================
  // Registers
  // ==========================================
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      s <= TOP_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  assign o_axi_awready = s.awready;
  assign o_axi_wready = s.wready;
  assign o_axi_bresp = s.bresp;
  assign o_axi_bvalid = s.bvalid;
  assign o_axi_arready = s.arready;
  assign o_axi_rdata = s.rdata;
  assign o_axi_rresp = s.rresp;
  assign o_axi_rvalid = s.rvalid;
  assign o_link_condition = s.cond;
  assign o_link_condition_report = s.report;
  assign o_irq = s.irq;

endmodule : lsf_link

// *** rtl/lsf_pkg.sv ***
package lsf_pkg;

  // ==========================================
  // Register map, byte addresses
  // ==========================================
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0C;
  localparam logic [7:0] REG_FRAME_COUNT = 8'h10;

  // ==========================================
  // Control register fields
  // ==========================================
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CTRL_MGMT_EN = 0;
  localparam int unsigned CTRL_MGMT_FAIL = 1;
  localparam int unsigned CTRL_MGMT_DEGRADE = 2;
  localparam int unsigned CTRL_TX_EN = 3;
  localparam int unsigned CTRL_WATCH_EN = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h18;

  // ==========================================
  // Status and interrupt fields
  // ==========================================
  localparam int unsigned STAT_W = 4;
  localparam int unsigned STAT_RXCLK_DEAD = 2;
  localparam int unsigned STAT_TX_BUSY = 3;
  localparam int unsigned INT_W = 2;
  localparam int unsigned INT_COND = 0;
  localparam int unsigned INT_FRAME = 1;
  localparam logic [INT_W-1:0] INT_RESET = 2'h0;
  localparam int unsigned STRB_LOW = 0;

  // ==========================================
  // Link condition, bit 0 fail, bit 1 degrade
  // ==========================================
  typedef logic [1:0] lsf_cond_t;
  localparam int unsigned COND_FAIL = 0;
  localparam int unsigned COND_DEGRADE = 1;
  localparam lsf_cond_t COND_OK = 2'h0;

  // ==========================================
  // Framing bytes
  // ==========================================
  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [7:0] ESC_BYTE = 8'h7D;
  localparam logic [7:0] ESC_XOR = 8'h20;
  localparam int unsigned COUNT_W = 32;

  // ==========================================
  // Timing
  // ==========================================
  localparam int unsigned CORE_CLK_MHZ = 25;
  localparam int unsigned RXCLK_TIMEOUT_NS = 2000;
  localparam int unsigned RXCLK_TIMEOUT_CYC = (RXCLK_TIMEOUT_NS * CORE_CLK_MHZ) / 1000;
  localparam int unsigned WATCH_W = 8;

  // ==========================================
  // Bus responses and framer states
  // ==========================================
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_DATA = 4'h2,
    TX_ESC = 4'h4,
    TX_EOF = 4'h8
  } lsf_tx_state_e;

endpackage : lsf_pkg
